// >>> rtl/lmtx_defs.svh
`ifndef LMTX_DEFS_SVH
`define LMTX_DEFS_SVH
// ----------------------------------------------------------------
// Target address
// ----------------------------------------------------------------
`define LMTX_ADDR_HI        5'h18
// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define LMTX_IDX_CFG        8'h00
`define LMTX_IDX_M1_FIRST   8'h01
`define LMTX_IDX_M1_LAST    8'h0B
`define LMTX_IDX_UPDATE     8'h0C
`define LMTX_IDX_INTENS     8'h0D
`define LMTX_IDX_M2_FIRST   8'h0E
`define LMTX_IDX_M2_LAST    8'h18
`define LMTX_IDX_PWM        8'h19
`define LMTX_IDX_RESET      8'hFF
// ----------------------------------------------------------------
// Reset values and trigger key
// ----------------------------------------------------------------
`define LMTX_RST_CFG        8'h00
`define LMTX_RST_COL        8'h00
`define LMTX_RST_INTENS     8'h00
`define LMTX_RST_PWM        8'h80
`define LMTX_TRIG_KEY       8'h00
// ----------------------------------------------------------------
// Configuration field positions
// ----------------------------------------------------------------
`define LMTX_CFG_SHD_BIT    7
`define LMTX_CFG_SEL_HI     4
`define LMTX_CFG_SEL_LO     3
`define LMTX_CFG_AEN_BIT    2
`define LMTX_CFG_GEO_HI     1
`define LMTX_CFG_GEO_LO     0
`define LMTX_CFG_WMASK      8'h9F
`endif

// >>> rtl/lmtx_pkg.sv
package lmtx_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_INDEX,
        ST_DATA,
        ST_ACK,
        ST_IGNORE
    } lmtx_state_t;

    typedef struct packed {
        logic       soft_shutdown_bit;
        logic [1:0] matrix_select_field;
        logic       audio_enable;
        logic [1:0] matrix_geometry_field;
    } lmtx_cfg_t;
endpackage

// >>> rtl/lmtx_port.sv
`timescale 1ns/1ns
`include "lmtx_defs.svh"
// What this block does
// - Write-only; reads are never acknowledged
// - Match address 11000 plus strap bits
// - Strap code selects low address bits
// - Sample data while clock stably high
// - Start condition begins address matching
// - Stop condition returns port to idle
// - Acknowledge matched address during ninth pulse
// - Second byte loads the register pointer
// - Data bytes written and acknowledged
// - Pointer advances on each data acknowledge
// - Decode the documented register map
// - Reset defaults: PWM 80h, rest zero
// - Config D7 is software shutdown
// - Config D4:D3 selects shown matrices
// - Config D2 selects audio intensity
// - Config D1:D0 selects matrix geometry
// - Column register holds eight row bits
// - Bit one lights that LED
// - Shadow data copied on update write
// - Reset trigger write restores all defaults
module lmtx_port
    import lmtx_pkg::*;
#(
    parameter int NCOL = 11
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    // Serial bus pins
    input  wire logic             scl_in,
    input  wire logic             sda_in,
    output logic                  sda_out,
    output logic                  sda_oe,
    // Address strap, already decoded to two bits
    input  wire logic [1:0]       strap_code,
    // Stored configuration and intensity
    output lmtx_cfg_t             cfg_out,
    output logic [7:0]            intensity_settings,
    output logic [7:0]            pulse_width_level,
    // Active column data, one row_output_bits byte per column
    output logic [NCOL*8-1:0]     m1_row_output_bits,
    output logic [NCOL*8-1:0]     m2_row_output_bits
);
    // Assertions run on the system clock and rest during reset
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Two stages per pin; only the second stage is looked at
    logic [1:0] scl_sync_q, scl_sync_d;
    logic [1:0] sda_sync_q, sda_sync_d;
    logic       scl_prev_q, sda_prev_q;
    logic [1:0] strap_s1_q, strap_s2_q;
    always_comb begin
        scl_sync_d = {scl_sync_q[0], scl_in};
        sda_sync_d = {sda_sync_q[0], sda_in};
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            strap_s1_q <= 2'h0;
            strap_s2_q <= 2'h0;
        end else begin
            scl_sync_q <= scl_sync_d;
            sda_sync_q <= sda_sync_d;
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
            strap_s1_q <= strap_code;
            strap_s2_q <= strap_s1_q;
        end
    end
    logic scl_s, sda_s, scl_rise, scl_fall, start_ev, stop_ev;
    logic [6:0] own_addr;

    // Bus conditions are data edges while the clock is high
    always_comb begin
        scl_s    = scl_sync_q[1];
        sda_s    = sda_sync_q[1];
        scl_rise = scl_s & ~scl_prev_q;
        scl_fall = ~scl_s & scl_prev_q;
        start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
        stop_ev  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
        own_addr = {`LMTX_ADDR_HI, strap_s2_q};
    end

    // ------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------
    lmtx_state_t st_q, st_d, ret_q, ret_d;
    logic [7:0]  shift_q, shift_d;
    logic [3:0]  bit_q, bit_d;
    logic [7:0]  ptr_q, ptr_d;
    logic        ack_q, ack_d;
    logic        ackhi_q, ackhi_d;
    logic        wr_d, wr_q;
    logic [7:0]  wr_idx_d, wr_idx_q, wr_dat_d, wr_dat_q;

    // Bits are taken on the rising clock edge, ack is driven from the
    // falling edge that ends bit 8 to the falling edge ending pulse 9
    always_comb begin
        st_d     = st_q;
        ret_d    = ret_q;
        shift_d  = shift_q;
        bit_d    = bit_q;
        ptr_d    = ptr_q;
        ack_d    = ack_q;
        ackhi_d  = ackhi_q;
        wr_d     = 1'b0;
        wr_idx_d = wr_idx_q;
        wr_dat_d = wr_dat_q;
        if (start_ev) begin
            st_d  = ST_ADDR;
            bit_d = 4'h0;
            ack_d = 1'b0;
        end else if (stop_ev) begin
            st_d  = ST_IDLE;
            ack_d = 1'b0;
        end else begin
            case (st_q)
                ST_ADDR, ST_INDEX, ST_DATA: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_s};
                        bit_d   = bit_q + 4'h1;
                    end
                    if (scl_fall && bit_q == 4'h8) begin
                        bit_d   = 4'h0;
                        ackhi_d = 1'b0;
                        st_d    = ST_ACK;
                        ack_d   = 1'b1;
                        ret_d   = ST_DATA;
                        if (st_q == ST_ADDR) begin
                            // Reads and foreign addresses are left alone
                            if (shift_q != {own_addr, 1'b0}) begin
                                ack_d = 1'b0;
                                st_d  = ST_IGNORE;
                            end else begin
                                ret_d = ST_INDEX;
                            end
                        end else if (st_q == ST_INDEX) begin
                            ptr_d = shift_q;
                        end else begin
                            wr_d     = 1'b1;
                            wr_idx_d = ptr_q;
                            wr_dat_d = shift_q;
                            ptr_d    = ptr_q + 8'h01;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_rise)
                        ackhi_d = 1'b1;
                    if (scl_fall && ackhi_q) begin
                        ack_d = 1'b0;
                        st_d  = ret_q;
                    end
                end
                ST_IGNORE: ack_d = 1'b0;
                default: st_d = ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_q     <= ST_IDLE;
            ret_q    <= ST_IDLE;
            shift_q  <= 8'h00;
            bit_q    <= 4'h0;
            ptr_q    <= 8'h00;
            ack_q    <= 1'b0;
            ackhi_q  <= 1'b0;
            wr_q     <= 1'b0;
            wr_idx_q <= 8'h00;
            wr_dat_q <= 8'h00;
        end else begin
            st_q     <= st_d;
            ret_q    <= ret_d;
            shift_q  <= shift_d;
            bit_q    <= bit_d;
            ptr_q    <= ptr_d;
            ack_q    <= ack_d;
            ackhi_q  <= ackhi_d;
            wr_q     <= wr_d;
            wr_idx_q <= wr_idx_d;
            wr_dat_q <= wr_dat_d;
        end
    end

    // Open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe  = ack_q;

    // ------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------
    logic [7:0] cfg_q, cfg_d, int_q, int_d, pwm_q, pwm_d;
    logic [7:0] sh1_q [NCOL], sh1_d [NCOL], sh2_q [NCOL], sh2_d [NCOL];
    logic [7:0] ac1_q [NCOL], ac1_d [NCOL], ac2_q [NCOL], ac2_d [NCOL];
    logic       do_reset, do_update;

    // Trigger registers act only on the key value, not on any write
    always_comb begin
        do_reset  = wr_q && wr_idx_q == `LMTX_IDX_RESET && wr_dat_q == `LMTX_TRIG_KEY;
        do_update = wr_q && wr_idx_q == `LMTX_IDX_UPDATE && wr_dat_q == `LMTX_TRIG_KEY;
        cfg_d = cfg_q;
        int_d = int_q;
        pwm_d = pwm_q;
        if (do_reset) begin
            cfg_d = `LMTX_RST_CFG;
            int_d = `LMTX_RST_INTENS;
            pwm_d = `LMTX_RST_PWM;
        end else if (wr_q) begin
            if (wr_idx_q == `LMTX_IDX_CFG)
                cfg_d = wr_dat_q & `LMTX_CFG_WMASK;
            if (wr_idx_q == `LMTX_IDX_INTENS)
                int_d = wr_dat_q;
            if (wr_idx_q == `LMTX_IDX_PWM)
                pwm_d = wr_dat_q;
        end
    end

    // One slot per column for each matrix: shadow then active copy
    for (genvar c = 0; c < NCOL; c++) begin : g_col
        always_comb begin
            sh1_d[c] = sh1_q[c];
            sh2_d[c] = sh2_q[c];
            ac1_d[c] = ac1_q[c];
            ac2_d[c] = ac2_q[c];
            if (do_reset) begin
                sh1_d[c] = `LMTX_RST_COL;
                sh2_d[c] = `LMTX_RST_COL;
                ac1_d[c] = `LMTX_RST_COL;
                ac2_d[c] = `LMTX_RST_COL;
            end else begin
                if (wr_q && wr_idx_q == `LMTX_IDX_M1_FIRST + 8'(c))
                    sh1_d[c] = wr_dat_q;
                if (wr_q && wr_idx_q == `LMTX_IDX_M2_FIRST + 8'(c))
                    sh2_d[c] = wr_dat_q;
                if (do_update) begin
                    ac1_d[c] = sh1_q[c];
                    ac2_d[c] = sh2_q[c];
                end
            end
        end
        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                sh1_q[c] <= `LMTX_RST_COL;
                sh2_q[c] <= `LMTX_RST_COL;
                ac1_q[c] <= `LMTX_RST_COL;
                ac2_q[c] <= `LMTX_RST_COL;
            end else begin
                sh1_q[c] <= sh1_d[c];
                sh2_q[c] <= sh2_d[c];
                ac1_q[c] <= ac1_d[c];
                ac2_q[c] <= ac2_d[c];
            end
        end

        // A one bit lights the LED at that row of this column
        assign m1_row_output_bits[c*8 +: 8] = ac1_q[c];
        assign m2_row_output_bits[c*8 +: 8] = ac2_q[c];
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cfg_q <= `LMTX_RST_CFG;
            int_q <= `LMTX_RST_INTENS;
            pwm_q <= `LMTX_RST_PWM;
        end else begin
            cfg_q <= cfg_d;
            int_q <= int_d;
            pwm_q <= pwm_d;
        end
    end

    // Decoded configuration fields
    always_comb begin
        cfg_out.soft_shutdown_bit     = cfg_q[`LMTX_CFG_SHD_BIT];
        cfg_out.matrix_select_field   = cfg_q[`LMTX_CFG_SEL_HI:`LMTX_CFG_SEL_LO];
        cfg_out.audio_enable          = cfg_q[`LMTX_CFG_AEN_BIT];
        cfg_out.matrix_geometry_field = cfg_q[`LMTX_CFG_GEO_HI:`LMTX_CFG_GEO_LO];
    end
    assign intensity_settings = int_q;
    assign pulse_width_level  = pwm_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_update_write;
        wr_q && wr_idx_q == `LMTX_IDX_UPDATE && wr_dat_q == 8'h00;
    endsequence
    property p_ack_no_read;
        (scl_fall && st_q == ST_ADDR && bit_q == 4'h8 && shift_q[0]) |=> !sda_oe;
    endproperty
    a_ack_no_read: assert property (p_ack_no_read) else $error("read acked");
    property p_ack_match;
        (scl_fall && st_q == ST_ADDR && bit_q == 4'h8 && !start_ev && !stop_ev
         && shift_q == {`LMTX_ADDR_HI, strap_s2_q, 1'b0}) |=> sda_oe;
    endproperty
    a_ack_match: assert property (p_ack_match) else $error("no address ack");
    property p_stop_idle;
        (stop_ev && !start_ev) |=> (st_q == ST_IDLE && !sda_oe);
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not idle");
    property p_start_addr;
        start_ev |=> (st_q == ST_ADDR && bit_q == 4'h0);
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("start missed");
    property p_ptr_inc;
        wr_d |=> ptr_q == wr_idx_q + 8'h01;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("pointer stuck");
    property p_update;
        s_update_write |=> ac1_q[0] == $past(sh1_q[0]) && ac2_q[0] == $past(sh2_q[0]);
    endproperty
    a_update: assert property (p_update) else $error("update lost");
    property p_soft_reset;
        do_reset |=> pulse_width_level == 8'h80 && cfg_q == 8'h00 && ac1_q[0] == 8'h00;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset");
    property p_cfg_mask;
        1'b1 |-> cfg_q[6:5] == 2'h0;
    endproperty
    a_cfg_mask: assert property (p_cfg_mask) else $error("unused bits set");
endmodule

// >>> verification/lmtx_master.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Bus master model: drives the serial clock and pulls data low
// ------------------------------------------------------------
module lmtx_master #(
    parameter int HALF = 10
) (
    // Clock and wire level
    input  wire logic sys_clk,
    input  wire logic sda_wire,
    // Driven pins
    output logic      scl,
    output logic      sda_low
);
    // Idle bus: clock high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // One bus phase; changes land at the falling edge, well off the sampling edge
    task automatic hold();
        repeat (HALF) @(negedge sys_clk);
    endtask

    // Start or repeated start: data falls while the clock is high
    task automatic bus_start();
        hold();
        sda_low = 1'b0;
        hold();
        scl = 1'b1;
        hold();
        sda_low = 1'b1;
        hold();
        scl = 1'b0;
    endtask

    // Stop: data rises while the clock is high, then the bus idles high
    task automatic bus_stop();
        hold();
        sda_low = 1'b1;
        hold();
        scl = 1'b1;
        hold();
        sda_low = 1'b0;
        hold();
    endtask

    // Data is set in the low phase and held through the high phase
    task automatic bus_bit(input logic b, output logic r);
        hold();
        sda_low = !b;
        hold();
        scl = 1'b1;
        hold();
        r = sda_wire;
        scl = 1'b0;
    endtask

    // Eight bits MSB first, then a released ninth pulse for the acknowledge
    task automatic bus_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bus_bit(b[i], r);
        end
        bus_bit(1'b1, r);
        ack = !r;
    endtask
endmodule

// >>> verification/led_matrix_i2c_write_port_bench.sv
`timescale 1ns/1ns
`include "lmtx_defs.svh"
module led_matrix_i2c_write_port_bench
    import lmtx_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic            sys_clk;
    logic            resetn;
    logic            scl;
    logic            sda_low;
    logic            sda_out;
    logic            sda_oe;
    logic [1:0]      strap_code;
    lmtx_cfg_t       cfg_out;
    logic [7:0]      intensity_settings;
    logic [7:0]      pulse_width_level;
    logic [87:0]     m1;
    logic [87:0]     m2;
    logic [87:0]     e1;
    logic [87:0]     e2;
    logic [7:0]      dbuf [0:24];
    logic [7:0]      d;
    logic            ack;
    int              miscompares = 0;
    int              checks_done = 0;
    // Open-drain wire with pull-up: low if either party pulls it
    wire             sda_wire = (sda_oe ? sda_out : 1'b1) & !sda_low;

    lmtx_port #(.NCOL(11)) lmtx_port_inst (
        .sys_clk(sys_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .strap_code(strap_code),
        .cfg_out(cfg_out), .intensity_settings(intensity_settings),
        .pulse_width_level(pulse_width_level),
        .m1_row_output_bits(m1), .m2_row_output_bits(m2)
    );
    lmtx_master #(.HALF(10)) lmtx_master_inst (
        .sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Wide enough for the largest grouped compare, so nothing is cut off
    task automatic chk(input logic [191:0] got, input logic [191:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] addr(input logic rd);
        return {`LMTX_ADDR_HI, strap_code, rd};
    endfunction

    // Full write transfer of n bytes from dbuf, every byte acknowledged
    task automatic wr(input logic [7:0] idx, input int n);
        lmtx_master_inst.bus_start();
        lmtx_master_inst.bus_byte(addr(1'b0), ack);
        chk(ack, 1'b1);
        lmtx_master_inst.bus_byte(idx, ack);
        chk(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            lmtx_master_inst.bus_byte(dbuf[i], ack);
            chk(ack, 1'b1);
        end
        lmtx_master_inst.bus_stop();
        chk(sda_oe, 1'b0);
    endtask

    task automatic wr1(input logic [7:0] idx, input logic [7:0] v);
        dbuf[0] = v;
        wr(idx, 1);
    endtask

    // Refused address: no acknowledge, so the master stops at once
    task automatic nak(input logic [7:0] a8);
        lmtx_master_inst.bus_start();
        lmtx_master_inst.bus_byte(a8, ack);
        chk(ack, 1'b0);
        lmtx_master_inst.bus_stop();
    endtask

    task automatic tend(input string s);
        $display("test %s finished, mismatches so far %0d", s, miscompares);
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, reset and watchdog
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // About 75 bytes at 270 cycles each; allow about four times that
    initial begin
        #800000;
        miscompares++;
        test_done();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        strap_code = 2'b00;
        repeat (8) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk(pulse_width_level, `LMTX_RST_PWM);
        chk({cfg_out, intensity_settings, m1, m2}, '0);
        tend("reset");
        // Each strap code: own address acked, a neighbour's and a read refused
        for (int k = 0; k < 4; k++) begin
            strap_code = 2'(k);
            repeat (4) @(negedge sys_clk);
            d = {k[0], 2'b11, k[1:0], k[0], k[1:0]};
            wr1(`LMTX_IDX_CFG, d);
            chk(cfg_out, {d[7], d[4:3], d[2], d[1:0]});
            nak({`LMTX_ADDR_HI, 2'(k + 1), 1'b0});
            nak(addr(1'b1));
        end
        tend("address and config");
        // One burst walks m1, the gap registers, m2 and the level register
        for (int i = 0; i < 25; i++) begin
            dbuf[i] = 8'(i * 37 + 5);
        end
        dbuf[11] = 8'h01;
        wr(`LMTX_IDX_M1_FIRST, 25);
        chk({m1, m2}, '0);
        chk(intensity_settings, dbuf[12]);
        chk(pulse_width_level, dbuf[24]);
        for (int c = 0; c < 11; c++) begin
            e1[c*8+:8] = dbuf[c];
            e2[c*8+:8] = dbuf[c+13];
        end
        wr1(`LMTX_IDX_UPDATE, `LMTX_TRIG_KEY);
        chk(m1, e1);
        chk(m2, e2);
        tend("burst and update");
        // Non-key update and an unmapped index leave the outputs alone
        wr1(`LMTX_IDX_M1_FIRST, 8'hFF);
        wr1(`LMTX_IDX_UPDATE, 8'h01);
        wr1(8'h1A, 8'h77);
        chk({m1, m2, intensity_settings, pulse_width_level}, {e1, e2, dbuf[12], dbuf[24]});
        wr1(`LMTX_IDX_UPDATE, `LMTX_TRIG_KEY);
        e1[7:0] = 8'hFF;
        chk(m1, e1);
        tend("ignored writes");
        // Repeated start drops a half-sent data byte
        d = cfg_out;
        lmtx_master_inst.bus_start();
        lmtx_master_inst.bus_byte(addr(1'b0), ack);
        lmtx_master_inst.bus_byte(`LMTX_IDX_CFG, ack);
        for (int i = 0; i < 4; i++) begin
            lmtx_master_inst.bus_bit(1'b1, ack);
        end
        dbuf[0] = 8'h5A;
        wr(`LMTX_IDX_INTENS, 1);
        chk(intensity_settings, 8'h5A);
        chk(cfg_out, d[5:0]);
        tend("repeated start");
        // Reset trigger restores every default
        wr1(`LMTX_IDX_RESET, `LMTX_TRIG_KEY);
        chk(pulse_width_level, `LMTX_RST_PWM);
        chk({cfg_out, intensity_settings, m1, m2}, '0);
        tend("soft reset");
        test_done();
    end
endmodule
